// file: logic/gpp_top.sv
// Eight-bit GPIO port with analog disable, pull-ups and APB registers
// Functional notes
// - Direction bit one makes pin output
// - Latch write stored, driven on outputs
// - Direction zero: pin is undriven input
// - Latch write on inputs not driven
// - Output pins read back latch value
// - Input reads pin; RMW read returns latch
// - Peripheral output drives pin, read shows pin
// - Reads show pin despite peripheral input use
// - Analog-disable one enables digital input
// - Reset clears direction and analog-disable
// - Float in standby: high-z, input low
// - Enabled interrupt pins keep input open
// - Float off: standby holds pin states
// - Pin level reaches interrupt circuit on digital pins, unless floated without interrupt enable
// - Pull-up bit one connects pull-up
// - Driven low pin disconnects pull-up
// - Comparator input enabled when disable zero
// - Comparator disable one blocks comparator input
// - Registers reset zero; dir, pull read back
`timescale 1ns/100ps
module gpp_top (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [gpp_pkg::GPP_W-1:0] pin_in,
    output logic [gpp_pkg::GPP_W-1:0] pin_out,
    output logic [gpp_pkg::GPP_W-1:0] pin_oe,
    output logic [gpp_pkg::GPP_W-1:0] pin_pullup_en,
    // Peripheral functions
    input wire logic [gpp_pkg::GPP_W-1:0] periph_oe,
    input wire logic [gpp_pkg::GPP_W-1:0] periph_out,
    output logic [gpp_pkg::GPP_W-1:0] periph_in,
    // External interrupt and analog paths
    input wire logic [gpp_pkg::GPP_W-1:0] ext_irq_enable,
    output logic [gpp_pkg::GPP_W-1:0] ext_irq_level,
    output logic [gpp_pkg::GPP_W-1:0] analog_in_en,
    output logic comparator_in_en,
    // Standby
    input wire logic standby_req
);
    import gpp_pkg::*;

    logic [GPP_W-1:0] port_output_latch_reg;
    logic [GPP_W-1:0] port_direction_select_reg;
    logic [GPP_W-1:0] pin_pullup_select_reg;
    logic [GPP_W-1:0] analog_input_disable_low_reg;
    logic [1:0] ctrl_reg;
    logic [GPP_W-1:0] pin_sync;
    logic [GPP_W-1:0] dig_en;
    logic [GPP_W-1:0] in_gate;
    logic [GPP_W-1:0] drv_oe_next;
    logic [GPP_W-1:0] drv_val_next;
    logic [GPP_W-1:0] pull_next;
    logic [GPP_W-1:0] pin_read;
    logic [31:0] rdata_next;
    logic addr_ok;
    logic wr_en;
    logic rd_en;
    logic standby_pin_float;
    logic comparator_input_disable;
    gpp_mode_t mode;
    logic lat_we;
    logic dir_we;
    logic pull_we;
    logic aid_we;
    logic ctrl_we;
    logic float_mode;
    logic hold_mode;
    logic [GPP_W-1:0] irq_gate;

    // Byte-zero write strobe for one register offset
    function automatic logic reg_hit(input logic en, input logic [11:0] a,
        input logic [3:0] strb, input logic [11:0] off);
        return en && strb[0] && (a == off);
    endfunction : reg_hit

    assign standby_pin_float = ctrl_reg[GPP_CTRL_FLOAT_BIT];
    assign comparator_input_disable = ctrl_reg[GPP_CTRL_CMPDIS_BIT];

    // Pin input synchroniser
    gpp_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d_async(pin_in),
        .q_sync(pin_sync)
    );

    // Standby mode tracker
    gpp_mode u_mode (
        .pclk(pclk),
        .presetn(presetn),
        .standby_req(standby_req),
        .standby_pin_float(standby_pin_float),
        .mode(mode)
    );

    // APB decode; writes land at the ready edge, reads load one edge earlier
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && !pready;
    always_comb begin
        case (paddr)
            GPP_OFF_LATCH, GPP_OFF_LATCH_RMW, GPP_OFF_DIR, GPP_OFF_PULL,
            GPP_OFF_AIDIS, GPP_OFF_CTRL, GPP_OFF_STAT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Per-register write strobes
    assign lat_we = reg_hit(wr_en, paddr, pstrb, GPP_OFF_LATCH);
    assign dir_we = reg_hit(wr_en, paddr, pstrb, GPP_OFF_DIR);
    assign pull_we = reg_hit(wr_en, paddr, pstrb, GPP_OFF_PULL);
    assign aid_we = reg_hit(wr_en, paddr, pstrb, GPP_OFF_AIDIS);
    assign ctrl_we = reg_hit(wr_en, paddr, pstrb, GPP_OFF_CTRL);

    // Standby mode decode
    assign float_mode = (mode == GPP_FLOAT);
    assign hold_mode = (mode == GPP_HOLD);

    // Ready one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Error flag, raised with ready on unmapped offsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    // Data latch: every write stored, regardless of direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_output_latch_reg <= GPP_RST_BYTE;
        end else if (lat_we) begin
            port_output_latch_reg <= pwdata[GPP_W-1:0];
        end
    end

    // Direction register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_direction_select_reg <= GPP_RST_BYTE;
        end else if (dir_we) begin
            port_direction_select_reg <= pwdata[GPP_W-1:0];
        end
    end

    // Pull-up select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_pullup_select_reg <= GPP_RST_BYTE;
        end else if (pull_we) begin
            pin_pullup_select_reg <= pwdata[GPP_W-1:0];
        end
    end

    // Analog input disable; only mapped bits exist
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_input_disable_low_reg <= GPP_RST_BYTE;
        end else if (aid_we) begin
            analog_input_disable_low_reg <= pwdata[GPP_W-1:0] & GPP_AID_MASK;
        end
    end

    // Control: float select and comparator disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= GPP_CTRL_RST;
        end else if (ctrl_we) begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    // Digital input enable per pin from analog disable bits
    assign dig_en = gpp_aid_to_pins(analog_input_disable_low_reg);

    // Input gate: blocked in float unless interrupt enabled
    always_comb begin
        in_gate = dig_en;
        if (float_mode) begin
            in_gate = dig_en & ext_irq_enable & GPP_IRQ_PINS;
        end
    end

    // Interrupt path gate: analog pins always blocked, others only in float
    assign irq_gate = float_mode ? in_gate : dig_en;

    // Drive selection: peripheral over port, float over all
    always_comb begin
        for (int i = 0; i < GPP_W; i++) begin
            if (periph_oe[i]) begin
                drv_oe_next[i] = 1'b1;
                drv_val_next[i] = periph_out[i];
            end else if (port_direction_select_reg[i]) begin
                drv_oe_next[i] = 1'b1;
                drv_val_next[i] = port_output_latch_reg[i];
            end else begin
                drv_oe_next[i] = 1'b0;
                drv_val_next[i] = 1'b0;
            end
        end
        if (float_mode) begin
            drv_oe_next = GPP_RST_BYTE;
            drv_val_next = GPP_RST_BYTE;
        end
    end

    // Pull-up per pin; dropped while the pin is driven low
    always_comb begin
        for (int i = 0; i < GPP_W; i++) begin
            pull_next[i] = pin_pullup_select_reg[i];
            if (drv_oe_next[i] && !drv_val_next[i]) begin
                pull_next[i] = 1'b0;
            end
        end
    end

    // Pin output value; hold mode freezes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= GPP_RST_BYTE;
        end else if (!hold_mode) begin
            pin_out <= drv_val_next;
        end
    end

    // Pin drive enable; hold mode freezes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= GPP_RST_BYTE;
        end else if (!hold_mode) begin
            pin_oe <= drv_oe_next;
        end
    end

    // Pull-up enable; hold mode freezes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_pullup_en <= GPP_RST_BYTE;
        end else if (!hold_mode) begin
            pin_pullup_en <= pull_next;
        end
    end

    // Peripheral input path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_in <= GPP_RST_BYTE;
        end else begin
            periph_in <= pin_sync & in_gate;
        end
    end

    // Interrupt input path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_level <= GPP_RST_BYTE;
        end else begin
            ext_irq_level <= pin_sync & irq_gate;
        end
    end

    // Analog path enable on shared pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_in_en <= GPP_RST_BYTE;
        end else begin
            analog_in_en <= ~dig_en;
        end
    end

    // Comparator input enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_in_en <= 1'b0;
        end else begin
            comparator_in_en <= !comparator_input_disable;
        end
    end

    // Pin view for reads: latch on output pins, pin otherwise
    always_comb begin
        for (int i = 0; i < GPP_W; i++) begin
            if (port_direction_select_reg[i] && !periph_oe[i]) begin
                pin_read[i] = port_output_latch_reg[i];
            end else begin
                pin_read[i] = pin_sync[i] & in_gate[i];
            end
        end
    end

    // Read mux; unmapped reads give zero
    always_comb begin
        rdata_next = GPP_ZERO32;
        case (paddr)
            GPP_OFF_LATCH: rdata_next[GPP_W-1:0] = pin_read;
            GPP_OFF_LATCH_RMW: rdata_next[GPP_W-1:0] = port_output_latch_reg;
            GPP_OFF_DIR: rdata_next[GPP_W-1:0] = port_direction_select_reg;
            GPP_OFF_PULL: rdata_next[GPP_W-1:0] = pin_pullup_select_reg;
            GPP_OFF_AIDIS: rdata_next[GPP_W-1:0] = analog_input_disable_low_reg;
            GPP_OFF_CTRL: rdata_next[1:0] = ctrl_reg;
            GPP_OFF_STAT: rdata_next[1:0] = mode;
            default: rdata_next = GPP_ZERO32;
        endcase
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= GPP_ZERO32;
        end else if (rd_en) begin
            prdata <= rdata_next;
        end
    end
endmodule : gpp_top

// file: logic/gpp_pkg.sv
// Package with register map, field layouts and constants for the GPIO port
package gpp_pkg;
    localparam int GPP_W = 8;
    localparam logic [7:0] GPP_RST_BYTE = 8'h00;
    // Register byte addresses
    localparam logic [11:0] GPP_OFF_LATCH = 12'h000;
    localparam logic [11:0] GPP_OFF_LATCH_RMW = 12'h004;
    localparam logic [11:0] GPP_OFF_DIR = 12'h008;
    localparam logic [11:0] GPP_OFF_PULL = 12'h00C;
    localparam logic [11:0] GPP_OFF_AIDIS = 12'h010;
    localparam logic [11:0] GPP_OFF_CTRL = 12'h014;
    localparam logic [11:0] GPP_OFF_STAT = 12'h018;
    // Control register fields
    localparam int GPP_CTRL_FLOAT_BIT = 0;
    localparam int GPP_CTRL_CMPDIS_BIT = 1;
    localparam logic [1:0] GPP_CTRL_RST = 2'h0;
    // Analog-disable bit positions for pins 4, 5, 6, 7
    localparam int GPP_AID_P4 = 0;
    localparam int GPP_AID_P5 = 1;
    localparam int GPP_AID_P6 = 4;
    localparam int GPP_AID_P7 = 5;
    localparam logic [7:0] GPP_AID_MASK = 8'h33;
    // Pins with external interrupt inputs: 0 to 5
    localparam logic [7:0] GPP_IRQ_PINS = 8'h3F;
    // Pins shared with the comparator inputs: 5 and 7
    localparam logic [7:0] GPP_CMP_PINS = 8'hA0;
    localparam logic [31:0] GPP_ZERO32 = 32'h0000_0000;
    localparam logic [1:0] GPP_ZERO2 = 2'h0;
    typedef enum logic [1:0] {GPP_RUN, GPP_FLOAT, GPP_HOLD} gpp_mode_t;

    // Map analog-disable register onto per-pin digital input enable
    function automatic logic [7:0] gpp_aid_to_pins(input logic [7:0] aid);
        logic [7:0] p;
        p = 8'hFF;
        p[4] = aid[GPP_AID_P4];
        p[5] = aid[GPP_AID_P5];
        p[6] = aid[GPP_AID_P6];
        p[7] = aid[GPP_AID_P7];
        return p;
    endfunction : gpp_aid_to_pins
endpackage : gpp_pkg

// file: logic/gpp_sync.sv
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/100ps
module gpp_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [gpp_pkg::GPP_W-1:0] d_async,
    output logic [gpp_pkg::GPP_W-1:0] q_sync
);
    import gpp_pkg::*;
    logic [GPP_W-1:0] s1_reg;
    logic [GPP_W-1:0] s2_reg;
    logic [GPP_W-1:0] s3_reg;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= GPP_RST_BYTE;
            s2_reg <= GPP_RST_BYTE;
            s3_reg <= GPP_RST_BYTE;
        end else begin
            s1_reg <= d_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_sync <= GPP_RST_BYTE;
        end else begin
            for (int i = 0; i < GPP_W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q_sync[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : gpp_sync

// file: logic/gpp_mode.sv
// Standby mode tracker: float or hold on stop/watch entry
`timescale 1ns/100ps
module gpp_mode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Standby request and float setting
    input wire logic standby_req,
    input wire logic standby_pin_float,
    // Mode out
    output gpp_pkg::gpp_mode_t mode
);
    import gpp_pkg::*;

    // Float setting sampled at the moment of standby entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= GPP_RUN;
        end else begin
            case (mode)
                GPP_RUN: begin
                    if (standby_req) begin
                        mode <= standby_pin_float ? GPP_FLOAT : GPP_HOLD;
                    end
                end
                GPP_FLOAT, GPP_HOLD: begin
                    if (!standby_req) begin
                        mode <= GPP_RUN;
                    end
                end
                default: begin
                    mode <= GPP_RUN;
                end
            endcase
        end
    end
endmodule : gpp_mode

// file: tb/gpp_props.sv
// Concurrent checks on the GPIO port bus and pin outputs
`timescale 1ns/100ps
module gpp_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and side paths
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup_en,
    input wire logic [7:0] periph_oe,
    input wire logic [7:0] ext_irq_level,
    input wire logic [7:0] analog_in_en,
    input wire logic comparator_in_en,
    input wire logic standby_req
);
    import gpp_pkg::*;
    logic [7:0] wd_reg;
    wire wr = psel & penable & pready & pwrite & pstrb[0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Last written byte, for output checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wd_reg <= 8'h00;
        else if (wr) wd_reg <= pwdata[7:0];
    end
    AST_TAKE: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready too long");
    AST_UNMAP: assert property (psel && penable && pready && paddr > GPP_OFF_STAT |-> pslverr)
        else $error("no error on unmapped place");
    AST_HIGH: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_DIR: assert property (wr && paddr == GPP_OFF_DIR && !standby_req && periph_oe == 8'h00
        |=> ##[0:1] pin_oe == wd_reg) else $error("drive enable differs");
    AST_PULL: assert property ((pin_oe & ~pin_out & pin_pullup_en) == 8'h00)
        else $error("pull-up on low pin");
    AST_IRQ: assert property ((!standby_req && $stable(pin_in)) [*6]
        |-> ext_irq_level[3:0] == pin_in[3:0]) else $error("irq level lags");
    AST_CMP: assert property (wr && paddr == GPP_OFF_CTRL
        |=> ##[0:1] comparator_in_en == !wd_reg[GPP_CTRL_CMPDIS_BIT]) else $error("cmp path");
    AST_AIN: assert property (wr && paddr == GPP_OFF_AIDIS && !standby_req
        |=> ##[0:1] analog_in_en == {~wd_reg[5:4], ~wd_reg[1:0], 4'h0}) else $error("analog");
endmodule : gpp_props

bind gpp_top gpp_props gpp_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .periph_oe(periph_oe),
    .ext_irq_level(ext_irq_level), .analog_in_en(analog_in_en),
    .comparator_in_en(comparator_in_en), .standby_req(standby_req));

// file: tb/gpp_pins.sv
// Model of the external pins: drivers, pull-ups and floating wires
`timescale 1ns/100ps
module gpp_pins (
    // Clock
    input wire logic pclk,
    // Device side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup_en,
    // Outside drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_lvl
);
    logic [7:0] flt_reg = 8'h55;
    // Undriven wire shows a changing pattern
    always_ff @(posedge pclk) flt_reg <= ~flt_reg;
    // Wire level from all drivers
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else if (pin_pullup_en[i]) pin_lvl[i] = 1'b1;
            else pin_lvl[i] = flt_reg[i];
        end
    end
endmodule : gpp_pins

// file: tb/gpp_top_test.sv
// Self-checking bench for the GPIO port: bus tasks and pin scenarios
`timescale 1ns/100ps
module gpp_top_test;
    import gpp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic standby_req = 1'b0, pready, pslverr, er, comparator_in_en;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_en, periph_in, ext_irq_level, analog_in_en;
    logic [7:0] periph_oe = 8'h00, periph_out = 8'h00, ext_irq_enable = 8'h00;
    logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
    int err_total = 0, checks = 0;
    initial forever #5 pclk = ~pclk;
    gpp_top gpp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .periph_oe(periph_oe),
        .periph_out(periph_out), .periph_in(periph_in), .ext_irq_enable(ext_irq_enable),
        .ext_irq_level(ext_irq_level), .analog_in_en(analog_in_en),
        .comparator_in_en(comparator_in_en), .standby_req(standby_req));
    gpp_pins gpp_pins_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));
    // Counts, verdict and stop
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // One bus transfer, held until ready, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                end_of_test();
            end
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        tick(1);
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    // Main sequence
    initial begin
        tick(3);
        presetn <= 1'b1;
        tick(1);
        chk({24'h0, pin_oe}, 32'h0);
        rchk(GPP_OFF_DIR, 32'h0);
        rchk(GPP_OFF_AIDIS, 32'h0);
        rchk(GPP_OFF_PULL, 32'h0);
        rchk(GPP_OFF_LATCH_RMW, 32'h0);
        rchk(12'h01C, 32'h0);
        chk({31'h0, er}, 32'h1);
        // Shared pins as analog inputs, then digital
        ext_en <= 8'hFF;
        ext_val <= 8'hA5;
        tick(6);
        chk({24'h0, analog_in_en}, 32'hF0);
        rchk(GPP_OFF_LATCH, 32'h05);
        wr(GPP_OFF_AIDIS, 32'h33);
        tick(6);
        rchk(GPP_OFF_LATCH, 32'hA5);
        rchk(GPP_OFF_AIDIS, 32'h33);
        chk({24'h0, analog_in_en}, 32'h0);
        chk({24'h0, periph_in}, 32'hA5);
        chk({24'h0, ext_irq_level}, 32'hA5);
        // Upper nibble output, lower nibble input
        ext_en <= 8'h0F;
        ext_val <= 8'h0A;
        wr(GPP_OFF_LATCH, 32'hA5);
        wr(GPP_OFF_DIR, 32'hF0);
        tick(6);
        chk({24'h0, pin_oe}, 32'hF0);
        chk({24'h0, pin_out & 8'hF0}, 32'hA0);
        rchk(GPP_OFF_LATCH, 32'hAA);
        rchk(GPP_OFF_LATCH_RMW, 32'hA5);
        wr(GPP_OFF_LATCH, 32'h3C);
        chk({24'h0, pin_out & 8'hF0}, 32'h30);
        chk({24'h0, pin_oe}, 32'hF0);
        rchk(GPP_OFF_LATCH, 32'h3A);
        // Pull-ups, dropped on pins driven low
        ext_en <= 8'h00;
        wr(GPP_OFF_PULL, 32'hFF);
        tick(2);
        chk({24'h0, pin_pullup_en}, 32'h3F);
        rchk(GPP_OFF_PULL, 32'hFF);
        // Peripheral drives pin 0 low
        periph_oe <= 8'h01;
        tick(7);
        chk({24'h0, pin_oe}, 32'hF1);
        chk({24'h0, pin_pullup_en}, 32'h3E);
        rchk(GPP_OFF_LATCH, 32'h3E);
        periph_oe <= 8'h00;
        // Comparator input enable
        wr(GPP_OFF_CTRL, 32'h2);
        chk({31'h0, comparator_in_en}, 32'h0);
        wr(GPP_OFF_CTRL, 32'h0);
        chk({31'h0, comparator_in_en}, 32'h1);
        // Standby with float off holds outputs
        standby_req <= 1'b1;
        tick(2);
        wr(GPP_OFF_LATCH, 32'hC3);
        tick(2);
        chk({24'h0, pin_out & 8'hF0}, 32'h30);
        chk({24'h0, pin_oe}, 32'hF0);
        rchk(GPP_OFF_STAT, 32'h2);
        standby_req <= 1'b0;
        tick(3);
        chk({24'h0, pin_out & 8'hF0}, 32'hC0);
        // Standby with float on; pin 0 keeps interrupt input
        wr(GPP_OFF_CTRL, 32'h1);
        ext_irq_enable <= 8'h01;
        ext_en <= 8'hFF;
        ext_val <= 8'hFF;
        standby_req <= 1'b1;
        tick(8);
        chk({24'h0, pin_oe}, 32'h0);
        chk({24'h0, ext_irq_level}, 32'h01);
        rchk(GPP_OFF_STAT, 32'h1);
        standby_req <= 1'b0;
        tick(8);
        chk({24'h0, pin_oe}, 32'hF0);
        end_of_test();
    end
endmodule : gpp_top_test
